// ---- bench/nbh_assertions.sv ----
`timescale 1ns/1ns
module nbh_assertions (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic done,
  input wire logic ce_n,
  input wire logic cle,
  input wire logic ale,
  input wire logic we_n,
  input wire logic re_n,
  input wire logic io_oe_n,
  input wire logic [7:0] io_out
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  sequence we_pulse_s;
    (!we_n) [*8] ##1 we_n;
  endsequence
  sequence re_pulse_s;
    (!re_n) [*8] ##1 re_n;
  endsequence
  cle_ale_excl_a: assert property (!(cle && ale))
    else $error("cle and ale high together");
  we_width_a: assert property ($fell(we_n) |-> we_pulse_s)
    else $error("write strobe width wrong");
  re_width_a: assert property ($fell(re_n) |-> re_pulse_s)
    else $error("read strobe width wrong");
  strobe_excl_a: assert property (!(!we_n && !re_n))
    else $error("both strobes low");
  write_drive_a: assert property (!we_n |-> !io_oe_n)
    else $error("bus not driven during latch");
  read_release_a: assert property (!re_n |-> io_oe_n)
    else $error("bus driven during read");
  latch_stable_a: assert property (!we_n && $past(!we_n) |-> $stable({cle, ale, io_out}))
    else $error("latch inputs moved during strobe");
  ce_strobe_a: assert property (!we_n || !re_n |-> !ce_n)
    else $error("strobe without select");
  done_pulse_a: assert property (done |=> !done)
    else $error("done longer than one cycle");
endmodule
bind nbh_host nbh_assertions u_chk (.mclk(mclk), .sys_rst(sys_rst), .done(done),
  .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n), .io_oe_n(io_oe_n),
  .io_out(io_out));

// ---- bench/nbh_flash_model.sv ----
`timescale 1ns/1ns
module nbh_flash_model (
  input wire logic ce_n,
  input wire logic cle,
  input wire logic ale,
  input wire logic we_n,
  input wire logic re_n,
  input wire logic wp_n,
  input wire logic [7:0] io,
  input wire logic [10:0] fail_blk,
  output logic rb_n,
  output logic [7:0] dq,
  output int faults
);
  logic [7:0] m[int];
  logic [7:0] pend[int];
  logic [7:0] a[5];
  logic [7:0] q;
  logic st, fl;
  int n, col, row, blk, last[int];
  int ks[$];
  function automatic logic [7:0] rd(input int k);
    return m.exists(k) ? m[k] : 8'hff;
  endfunction
  function automatic logic bad(input int b);
    return rd(b << 18 | 'h800) !== 8'hff || rd(b << 18 | 'h1800) !== 8'hff;
  endfunction
  initial
  begin
    rb_n = 1; st = 0; fl = 0; faults = 0; n = 0; q = 8'h00;
    m['h80800] = 8'h00;
    m['h141800] = 8'h00;
  end
  // Unselected or idle: inverse of last byte, never a stale copy
  assign dq = (!ce_n && !re_n) ? q : ~q;
  always @(posedge we_n)
  begin
    if (!ce_n && cle)
    begin
      if ((io == 8'h30 || io == 8'h10) && n != 5 || io == 8'hd0 && n != 3)
        faults++;
      blk = row >> 6;
      if ((io == 8'h10 || io == 8'hd0) && bad(blk))
        faults++;
      if (io == 8'h10 && wp_n)
      begin
        if (last.exists(blk) && (row & 63) <= last[blk])
          faults++;
        fl = (blk == fail_blk);
        if (!fl)
        begin
          foreach (pend[k]) m[k] = pend[k];
          last[blk] = row & 63;
        end
      end
      if (io == 8'hd0 && wp_n)
      begin
        ks.delete();
        foreach (m[k]) if (k >> 18 == blk) ks.push_back(k);
        foreach (ks[i]) m.delete(ks[i]);
        last.delete(blk);
        fl = 0;
      end
      if (io == 8'h80)
        pend.delete();
      st = (io == 8'h70);
      n = 0;
      if (io inside {8'h30, 8'h10, 8'hd0, 8'hff, 8'h3f})
      begin
        rb_n = 0;
        #200 rb_n = 1;
      end
    end
    else if (!ce_n && ale && n < 5)
    begin
      a[n] = io;
      n++;
      if (n == 3)
        row = {a[2][0], a[1], a[0]};
      if (n == 5)
      begin
        row = {a[4][0], a[3], a[2]};
        col = {a[1][3:0], a[0]};
      end
    end
    else if (!ce_n)
    begin
      pend[row << 12 | col] = io;
      col++;
    end
  end
  always @(negedge re_n)
    if (!ce_n)
      q = st ? {wp_n, rb_n, 5'h00, fl} : rd(row << 12 | col);
  always @(posedge re_n)
    if (!st)
      col++;
endmodule

// ---- bench/testbench.sv ----
`timescale 1ns/1ns
module testbench;
  import nbh_pkg::*;
  logic mclk, sys_rst, req_valid, wr_valid, req_ready, wr_ready, rd_valid, done;
  logic ce_n, cle, ale, we_n, re_n, wp_n, rb_n, io_oe_n;
  logic [2:0] req_op;
  logic [BLK_W-1:0] req_block;
  logic [PAGE_W-1:0] req_page;
  logic [COL_W-1:0] req_col;
  logic [15:0] req_len;
  logic [7:0] wr_data, rd_data, io_out, fdq, io_in;
  logic [1:0] result, r;
  logic [10:0] fail_blk;
  logic [7:0] rq[$];
  int mismatches, samples_checked, faults;
  assign io_in = io_oe_n ? fdq : io_out;
  nbh_host DUT (.mclk(mclk), .sys_rst(sys_rst), .req_valid(req_valid),
    .req_ready(req_ready), .req_op(req_op), .req_block(req_block), .req_page(req_page),
    .req_col(req_col), .req_len(req_len), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_data(wr_data), .rd_valid(rd_valid), .rd_data(rd_data), .done(done),
    .result(result), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n),
    .wp_n(wp_n), .rb_n(rb_n), .io_in(io_in), .io_out(io_out), .io_oe_n(io_oe_n));
  nbh_flash_model u_flash (.ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
    .re_n(re_n), .wp_n(wp_n), .io(io_out), .fail_blk(fail_blk), .rb_n(rb_n),
    .dq(fdq), .faults(faults));
  initial
  begin
    mclk = 0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    if (rd_valid)
      rq.push_back(rd_data);
    if (wr_valid && wr_ready)
      wr_data <= #1 wr_data + 8'h01;
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tally_and_finish();
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Long bound: up to 20000 cycles waiting for done
  task automatic req(input logic [2:0] op, input int b, input int pg, input int c,
    input int ln);
    int i;
    rq.delete();
    chk("req_ready", 1, req_ready);
    req_op = op; req_block = b; req_page = pg; req_col = c; req_len = ln;
    req_valid = 1;
    @(posedge mclk);
    #1 req_valid = 0;
    i = 0;
    while (done !== 1'b1 && i < 20000)
    begin
      @(posedge mclk);
      #1 i++;
    end
    if (i >= 20000)
    begin
      mismatches++;
      tally_and_finish();
    end
    r = result;
  endtask
  task automatic scan_and_refuse();
    for (int b = 0; b < 7; b++)
      req(OP_SCAN, b == 6 ? 2047 : b, 0, 0, 1);
    req(OP_PROG, 2, 0, 0, 1);
    chk("prog_bad", 2'h2, r);
    req(OP_ERASE, 5, 0, 0, 1);
    chk("erase_bad", 2'h2, r);
  endtask
  task automatic prog_order();
    wr_data = 8'h10;
    req(OP_PROG, 1, 4, 0, 2);
    chk("prog_first", 2'h0, r);
    req(OP_READ, 1, 4, 0, 2);
    chk("rd0", 8'h10, rq[0]);
    chk("rd1", 8'h11, rq[1]);
    req(OP_PROG, 1, 3, 0, 1);
    chk("prog_back", 2'h2, r);
    req(OP_PROG, 1, 5, 0, 1);
    chk("prog_next", 2'h0, r);
  endtask
  task automatic prog_fail();
    fail_blk = 11'h003;
    wr_data = 8'h40;
    req(OP_PROG, 3, 0, 0, 2);
    chk("prog_fail", 2'h1, r);
    fail_blk = 11'h400;
    wr_data = 8'h40;
    req(OP_PROG, 3, 0, 0, 2);
    chk("prog_spare", 2'h0, r);
    req(OP_READ, 3, 0, 0, 2);
    chk("remap0", 8'h40, rq[0]);
    chk("remap1", 8'h41, rq[1]);
  endtask
  task automatic erase_and_end();
    req(OP_ERASE, 1, 0, 0, 1);
    chk("erase", 2'h0, r);
    req(OP_READ, 1, 4, 0, 1);
    chk("erased", 8'hff, rq[0]);
    req(OP_READ, 0, 0, 12'h800, 1);
    chk("blk0", 8'hff, rq[0]);
    req(OP_CACHE_END, 0, 0, 0, 1);
    chk("cache_end", 2'h0, r);
    req(OP_RESET, 0, 0, 0, 1);
    chk("reset", 2'h0, r);
    chk("wire_faults", 8'h00, faults[7:0]);
  endtask
  initial
  begin
    sys_rst = 1; req_valid = 0; wr_valid = 1; wr_data = 8'h00; fail_blk = 11'h400;
    req_op = OP_READ; req_block = 0; req_page = 0; req_col = 0; req_len = 16'h0001;
    mismatches = 0; samples_checked = 0;
    repeat (4) @(posedge mclk);
    #1 sys_rst = 0;
    scan_and_refuse();
    prog_order();
    prog_fail();
    erase_and_end();
    tally_and_finish();
  end
endmodule

// ---- src/nbh_bus_cycle.sv ----
`timescale 1ns/1ns
// One latch or read strobe on the multiplexed bus
module nbh_bus_cycle
  import nbh_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic [1:0] kind,
  input wire logic [7:0] wdata,
  input wire logic [7:0] io_in,
  output logic done,
  output logic [7:0] rdata,
  output logic cle,
  output logic ale,
  output logic we_n,
  output logic re_n,
  output logic [7:0] io_out,
  output logic io_oe_n
);
  // kind: 0 command, 1 address, 2 data write, 3 data read
  logic [7:0] io_s1;
  logic [7:0] io_s2;
  logic [7:0] cnt;
  logic busy;
  logic [1:0] k;
  always_ff @(posedge mclk)
  begin
    io_s1 <= io_in;
    io_s2 <= io_s1;
  end
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      busy <= 1'b0;
      cnt <= 8'h00;
      k <= 2'h0;
      cle <= 1'b0;
      ale <= 1'b0;
      we_n <= 1'b1;
      re_n <= 1'b1;
      io_out <= 8'h00;
      io_oe_n <= 1'b1;
      done <= 1'b0;
      rdata <= 8'h00;
    end
    else
    begin
      done <= 1'b0;
      if (start && !busy)
      begin
        busy <= 1'b1;
        k <= kind;
        cnt <= 8'h00;
        cle <= (kind == 2'h0);
        ale <= (kind == 2'h1);
        io_out <= wdata;
        io_oe_n <= (kind == 2'h3);
        we_n <= (kind == 2'h3);
        re_n <= (kind != 2'h3);
      end
      else if (busy)
      begin
        cnt <= cnt + 8'h01;
        if (cnt == 8'(STROBE_CYC))
        begin
          we_n <= 1'b1;
          re_n <= 1'b1;
          // Two sync stages plus strobe time covers access delay
          if (k == 2'h3)
            rdata <= io_s2;
        end
        if (cnt == 8'(2 * STROBE_CYC))
        begin
          busy <= 1'b0;
          done <= 1'b1;
          cle <= 1'b0;
          ale <= 1'b0;
          io_oe_n <= 1'b1;
        end
      end
    end
  end
endmodule

// ---- src/nbh_host.sv ----
`timescale 1ns/1ns
module nbh_host
  import nbh_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [2:0] req_op,
  input wire logic [BLK_W-1:0] req_block,
  input wire logic [PAGE_W-1:0] req_page,
  input wire logic [COL_W-1:0] req_col,
  input wire logic [15:0] req_len,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [7:0] wr_data,
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic done,
  output logic [1:0] result,
  output logic ce_n,
  output logic cle,
  output logic ale,
  output logic we_n,
  output logic re_n,
  output logic wp_n,
  input wire logic rb_n,
  input wire logic [7:0] io_in,
  output logic [7:0] io_out,
  output logic io_oe_n
);
  // result: 0 ok, 1 failed and retired, 2 refused (bad block or page out of order), 3 no spare
  typedef enum logic [8:0] {
    S_IDLE = 9'h001, S_CMD = 9'h002, S_ADDR = 9'h004, S_DATA = 9'h008,
    S_CMD2 = 9'h010, S_BUSY = 9'h020, S_STAT = 9'h040, S_STRD = 9'h080,
    S_FIN = 9'h100
  } nbh_state_t;
  nbh_state_t state;
  logic [BLK_W-1:0] remap [NUM_BLK];
  logic bad [NUM_BLK];
  logic [PAGE_W:0] last_page [NUM_BLK];
  logic [BLK_W-1:0] spare_ptr;
  logic [2:0] op;
  logic [BLK_W-1:0] lblk;
  logic [BLK_W-1:0] pblk;
  logic [PAGE_W-1:0] page;
  logic [COL_W-1:0] col;
  logic [15:0] len;
  logic [2:0] acnt;
  logic scan_pass;
  logic polling;
  logic [11:0] wait_cnt;
  logic rb_s1;
  logic rb_s2;
  logic bc_start;
  logic [1:0] bc_kind;
  logic [7:0] bc_wdata;
  logic bc_done;
  logic [7:0] bc_rdata;
  logic [7:0] addr_byte;
  logic [BLK_W+PAGE_W-1:0] row;
  always_ff @(posedge mclk)
  begin
    rb_s1 <= rb_n;
    rb_s2 <= rb_s1;
  end
  assign row = {pblk, page};
  always_comb
  begin
    unique case (acnt)
      3'h0: addr_byte = col[7:0];
      3'h1: addr_byte = {4'h0, col[11:8]};
      3'h2: addr_byte = row[7:0];
      3'h3: addr_byte = row[15:8];
      default: addr_byte = {7'h00, row[16]};
    endcase
  end
  assign req_ready = (state == S_IDLE);
  logic bc_done_idle;
  logic bc_busy;
  // Byte is consumed at the edge that starts its bus cycle
  assign wr_ready = (state == S_DATA) && (op == OP_PROG) && bc_done_idle;
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      bc_busy <= 1'b0;
    else if (bc_start)
      bc_busy <= 1'b1;
    else if (bc_done)
      bc_busy <= 1'b0;
  end
  assign bc_done_idle = !bc_busy;
  assign bc_start = !bc_busy && !(state == S_IDLE || state == S_BUSY || state == S_FIN)
    && !(state == S_DATA && op == OP_PROG && !wr_valid);
  always_comb
  begin
    bc_kind = 2'h0;
    bc_wdata = 8'h00;
    unique case (state)
      S_CMD:
      begin
        bc_wdata = (op == OP_PROG) ? CMD_PROG0 : (op == OP_ERASE) ? CMD_ERASE0
          : (op == OP_CACHE_END) ? CMD_CACHE_END : (op == OP_RESET) ? CMD_RESET
          : CMD_READ0;
      end
      S_ADDR:
      begin
        bc_kind = 2'h1;
        bc_wdata = addr_byte;
      end
      S_DATA:
      begin
        bc_kind = (op == OP_PROG) ? 2'h2 : 2'h3;
        bc_wdata = wr_data;
      end
      S_CMD2:
        bc_wdata = (op == OP_PROG) ? CMD_PROG1 : (op == OP_ERASE) ? CMD_ERASE1 : CMD_READ1;
      S_STAT:
        bc_wdata = CMD_STATUS;
      S_STRD:
        bc_kind = 2'h3;
      default:
      begin
        bc_kind = 2'h0;
        bc_wdata = 8'h00;
      end
    endcase
  end
  nbh_bus_cycle u_cycle (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .start(bc_start),
    .kind(bc_kind),
    .wdata(bc_wdata),
    .io_in(io_in),
    .done(bc_done),
    .rdata(bc_rdata),
    .cle(cle),
    .ale(ale),
    .we_n(we_n),
    .re_n(re_n),
    .io_out(io_out),
    .io_oe_n(io_oe_n)
  );
  // Tables reset only for the scan range; cleared here one entry a cycle would cost time
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      state <= S_IDLE;
      op <= OP_READ;
      lblk <= '0;
      pblk <= '0;
      page <= '0;
      col <= '0;
      len <= 16'h0000;
      acnt <= 3'h0;
      scan_pass <= 1'b0;
      polling <= 1'b0;
      wait_cnt <= 12'h000;
      spare_ptr <= BLK_W'(NUM_BLK - 1);
      done <= 1'b0;
      result <= 2'h0;
      rd_valid <= 1'b0;
      rd_data <= 8'h00;
      ce_n <= 1'b1;
      wp_n <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      rd_valid <= 1'b0;
      unique case (state)
        S_IDLE:
          if (req_valid)
          begin
            op <= req_op;
            lblk <= req_block;
            pblk <= remap[req_block];
            page <= (req_op == OP_SCAN) ? '0 : req_page;
            col <= (req_op == OP_SCAN) ? SPARE_COL : req_col;
            len <= (req_op == OP_SCAN) ? 16'h0001 : req_len;
            scan_pass <= 1'b0;
            acnt <= 3'h0;
            if (req_op == OP_SCAN)
            begin
              pblk <= req_block;
              remap[req_block] <= req_block;
              bad[req_block] <= 1'b0;
              last_page[req_block] <= '0;
            end
            if ((req_op == OP_PROG || req_op == OP_ERASE) && bad[remap[req_block]])
            begin
              result <= 2'h2;
              state <= S_FIN;
            end
            else if (req_op == OP_PROG && last_page[req_block] != '0
              && {1'b0, req_page} < last_page[req_block])
            begin
              result <= 2'h2;
              state <= S_FIN;
            end
            else
            begin
              ce_n <= 1'b0;
              wp_n <= 1'b1;
              result <= 2'h0;
              state <= S_CMD;
            end
          end
        S_CMD:
          if (bc_done)
          begin
            if (op == OP_CACHE_END)
            begin
              wait_cnt <= 12'h000;
              state <= S_BUSY;
            end
            else if (op == OP_RESET)
            begin
              wait_cnt <= 12'h000;
              state <= S_BUSY;
            end
            else
            begin
              // Erase carries only the three row cycles
              acnt <= (op == OP_ERASE) ? 3'h2 : 3'h0;
              state <= S_ADDR;
            end
          end
        S_ADDR:
          if (bc_done)
          begin
            acnt <= acnt + 3'h1;
            if (acnt == 3'(ADDR_CYCLES - 1))
              state <= (op == OP_PROG) ? S_DATA : S_CMD2;
          end
        S_DATA:
          if (bc_done)
          begin
            len <= len - 16'h0001;
            if (op != OP_PROG)
            begin
              rd_valid <= (op != OP_SCAN);
              rd_data <= bc_rdata;
              if (op == OP_SCAN && bc_rdata != ERASED)
                bad[pblk] <= 1'b1;
            end
            if (len == 16'h0001)
            begin
              if (op == OP_PROG)
                state <= S_CMD2;
              else if (op == OP_SCAN && !scan_pass)
              begin
                scan_pass <= 1'b1;
                page <= 6'h01;
                len <= 16'h0001;
                acnt <= 3'h0;
                state <= S_CMD;
              end
              else
                state <= S_FIN;
            end
          end
        S_CMD2:
          if (bc_done)
          begin
            wait_cnt <= 12'h000;
            state <= S_BUSY;
          end
        S_BUSY:
        begin
          // Skip the tWB window before trusting ready
          if (wait_cnt != 12'hfff)
            wait_cnt <= wait_cnt + 12'h001;
          if (wait_cnt >= 12'(WHR_CYC) && rb_s2)
          begin
            if (op == OP_PROG || op == OP_ERASE)
              state <= S_STAT;
            else if (op == OP_CACHE_END || op == OP_RESET)
              state <= S_FIN;
            else
              state <= S_DATA;
          end
        end
        S_STAT:
          if (bc_done)
            state <= S_STRD;
        S_STRD:
          if (bc_done)
          begin
            if (!bc_rdata[ST_RDY_BIT])
              state <= S_STAT;
            else if (bc_rdata[ST_FAIL_BIT])
            begin
              bad[pblk] <= 1'b1;
              if (bad[spare_ptr] || spare_ptr == '0)
                result <= 2'h3;
              else
              begin
                remap[lblk] <= spare_ptr;
                spare_ptr <= spare_ptr - BLK_W'(1);
                last_page[lblk] <= '0;
                result <= 2'h1;
              end
              state <= S_FIN;
            end
            else
            begin
              if (op == OP_PROG)
                last_page[lblk] <= {1'b0, page} + 7'h01;
              else
                last_page[lblk] <= '0;
              state <= S_FIN;
            end
          end
        S_FIN:
        begin
          ce_n <= 1'b1;
          wp_n <= 1'b0;
          done <= 1'b1;
          state <= S_IDLE;
        end
        default:
          state <= S_IDLE;
      endcase
    end
  end
endmodule

// ---- src/nbh_pkg.sv ----
package nbh_pkg;
  localparam int CLK_NS = 4;
  localparam int BLK_W = 11;
  localparam int PAGE_W = 6;
  localparam int COL_W = 12;
  localparam int NUM_BLK = 2048;
  localparam logic [COL_W-1:0] SPARE_COL = 12'h800;
  localparam logic [7:0] ERASED = 8'hff;
  localparam logic [7:0] CMD_READ0 = 8'h00;
  localparam logic [7:0] CMD_READ1 = 8'h30;
  localparam logic [7:0] CMD_PROG0 = 8'h80;
  localparam logic [7:0] CMD_PROG1 = 8'h10;
  localparam logic [7:0] CMD_ERASE0 = 8'h60;
  localparam logic [7:0] CMD_ERASE1 = 8'hd0;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_RESET = 8'hff;
  localparam logic [7:0] CMD_CACHE_END = 8'h3f;
  localparam int ST_FAIL_BIT = 0;
  localparam int ST_RDY_BIT = 6;
  localparam int STROBE_NS = 28;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int WHR_NS = 100;
  localparam int WHR_CYC = (WHR_NS + CLK_NS - 1) / CLK_NS;
  localparam int RST_BUSY_US = 5;
  localparam int RST_BUSY_CYC = RST_BUSY_US * 1000 / CLK_NS;
  localparam int ADDR_CYCLES = 5;
  localparam logic [2:0] OP_READ = 3'h0;
  localparam logic [2:0] OP_PROG = 3'h1;
  localparam logic [2:0] OP_ERASE = 3'h2;
  localparam logic [2:0] OP_SCAN = 3'h3;
  localparam logic [2:0] OP_CACHE_END = 3'h4;
  localparam logic [2:0] OP_RESET = 3'h5;
endpackage
